// ===== ppw_host_model.sv
`timescale 1ns/1ns
module ppw_host_model (
  input wire logic i_mclk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [4:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  initial begin
    o_address = 5'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'hf;
  end

  // request held until waitrequest is sampled low
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= 4'hf;
    o_write <= 1'b1;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    o_write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge i_mclk);
    o_address <= a;
    o_read <= 1'b1;
    do @(posedge i_mclk); while (i_waitrequest !== 1'b0);
    q = i_readdata;
    o_read <= 1'b0;
  endtask

  // while waiting for wake, only the wake source is unmasked
  task automatic arm_wake();
    wr(5'h08, 32'h0000_0100);
  endtask
endmodule

// ===== ppw_params.svh
`ifndef PPW_PARAMS_SVH
`define PPW_PARAMS_SVH

// timing
`define PPW_CLK_NS 20
`define PPW_US_NS 1000
`define PPW_MS_NS 1000000
`define PPW_BLINK_MS 100
`define PPW_TXNLP_STEP_MS 256
`define PPW_RXNLP_STEP_MS 64

// byte offsets
`define PPW_OFF_CTRL 5'h00
`define PPW_OFF_STAT 5'h04
`define PPW_OFF_IMASK 5'h08
`define PPW_OFF_ISRC 5'h0C
`define PPW_OFF_WAKE 5'h10
`define PPW_OFF_MISC 5'h14

// control fields
`define PPW_CTRL_PD 0
`define PPW_CTRL_ENERGY_DETECT_SLEEP 1
`define PPW_CTRL_TXNLP 2
`define PPW_CTRL_TXINT 4
`define PPW_CTRL_SINGLE 6
`define PPW_CTRL_RXINT 8

// status fields
`define PPW_STAT_ENERGY 0
`define PPW_STAT_SLEEP 1
`define PPW_STAT_PD 2
`define PPW_STAT_STRAP1 3
`define PPW_STAT_STRAP2 4

// interrupt fields
`define PPW_IRQ_ENERGY 1
`define PPW_IRQ_WOL 8

// wake control/status fields
`define PPW_WAKE_EN 0
`define PPW_WAKE_RCV 4
`define PPW_WAKE_CONF 8
`define PPW_WAKE_SCLR 9
`define PPW_WAKE_F1 10
`define PPW_WAKE_F2 12

// reset values
`define PPW_CTRL_RST 32'h0000_0000
`define PPW_IMASK_RST 32'h0000_0000
`define PPW_WAKE_RST 32'h0000_0000
`define PPW_MISC_RST 32'h0000_0064

`endif

// ===== ppw_pkg.sv
package ppw_pkg;
  typedef enum logic [1:0] {
    PPW_ST_ON = 2'h0,
    PPW_ST_SLEEP = 2'h1,
    PPW_ST_ARMED = 2'h3,
    PPW_ST_WAKE = 2'h2
  } ppw_state_t;

  typedef enum logic [1:0] {
    PPW_FN_DEFAULT = 2'h0,
    PPW_FN_IRQ = 2'h1,
    PPW_FN_WAKE = 2'h2,
    PPW_FN_ACT = 2'h3
  } ppw_pin_fn_t;
endpackage

// ===== ppw_top.sv
`timescale 1ns/1ns
`include "ppw_params.svh"
module ppw_top
  import ppw_pkg::*;
#(
  parameter int unsigned MS_CYC = `PPW_MS_NS / `PPW_CLK_NS,
  parameter int unsigned BLINK_CYC = `PPW_BLINK_MS * MS_CYC
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic i_soft_rst,
  input wire logic i_regulator_disable_strap_strap,
  input wire logic i_irq_pin_select_strap,
  input wire logic i_link_up,
  input wire logic i_carrier_sense,
  input wire logic i_speed_100,
  input wire logic i_isolate,
  input wire logic i_nlp_rx,
  input wire logic i_rx_energy,
  input wire logic i_energy_lost,
  input wire logic [3:0] i_frame_match,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_indicator_one,
  output logic o_indicator_two,
  output logic o_interrupt_out_n,
  output logic o_refclk_output_en,
  output logic o_xcvr_power_down,
  output logic o_energy_detect_sleep,
  output logic o_xcvr_reset,
  output logic o_tx_nlp,
  output logic o_rx_drop
);
  localparam int unsigned US_CYC = `PPW_US_NS / `PPW_CLK_NS;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pin_val(input logic [1:0] fn, input logic dflt,
                                   input logic act, input logic irq,
                                   input logic wake, input logic pol);
    logic v;
    unique case (fn)
      PPW_FN_DEFAULT: v = dflt;
      PPW_FN_IRQ: v = irq;
      PPW_FN_WAKE: v = wake;
      PPW_FN_ACT: v = act;
    endcase
    return v ^ pol;
  endfunction

  logic strap1_q, strap2_q;
  logic wait_q;
  logic [31:0] rdata_q, rd_mux;
  logic pd_q, pd_prev_q, energy_detect_sleep_en_q, txnlp_q, single_q;
  logic [1:0] txint_q, rxint_q;
  logic [1:0] imask_q, isrc_q, isrc_d;
  logic [3:0] wen_q, rcv_q, rcv_d;
  logic wconf_q, sclr_q;
  logic [1:0] f1_q, f2_q;
  logic [15:0] misc_q;
  logic [31:0] ctrl_rd, wake_rd, imask_rd, ctrl_w, wake_w, imask_w, clr_w;
  logic [31:0] misc_w;
  ppw_state_t st_q;
  logic line_energy_q, sleeping;
  logic [31:0] win_cnt_q, nlp_cnt_q, sc_cnt_q, blink_cnt_q;
  logic [31:0] tx_lim, rx_lim;
  logic blink_q, wake_act_q, wake_evt, energy_evt;
  logic wr_acc, rd_acc, irq_lvl, act_lvl;

  assign wr_acc = i_avs_write && !wait_q;
  assign rd_acc = i_avs_read && !wait_q;
  assign sleeping = (st_q == PPW_ST_SLEEP) || (st_q == PPW_ST_ARMED);
  assign wake_evt = |(i_frame_match & wen_q);
  assign energy_evt = (st_q == PPW_ST_WAKE);
  assign tx_lim = 32'((4 - int'(txint_q)) * `PPW_TXNLP_STEP_MS * MS_CYC);
  assign rx_lim = 32'((1 + int'(rxint_q)) * `PPW_RXNLP_STEP_MS * MS_CYC);

  // straps caught while hardware reset is held
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      strap1_q <= i_regulator_disable_strap_strap;
      strap2_q <= i_irq_pin_select_strap;
    end
  end

  // register views
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`PPW_CTRL_PD] = pd_q;
    ctrl_rd[`PPW_CTRL_ENERGY_DETECT_SLEEP] = energy_detect_sleep_en_q;
    ctrl_rd[`PPW_CTRL_TXNLP] = txnlp_q;
    ctrl_rd[`PPW_CTRL_TXINT +: 2] = txint_q;
    ctrl_rd[`PPW_CTRL_SINGLE] = single_q;
    ctrl_rd[`PPW_CTRL_RXINT +: 2] = rxint_q;
    imask_rd = 32'h0000_0000;
    imask_rd[`PPW_IRQ_ENERGY] = imask_q[0];
    imask_rd[`PPW_IRQ_WOL] = imask_q[1];
    wake_rd = 32'h0000_0000;
    wake_rd[`PPW_WAKE_EN +: 4] = wen_q;
    wake_rd[`PPW_WAKE_RCV +: 4] = rcv_q;
    wake_rd[`PPW_WAKE_CONF] = wconf_q;
    wake_rd[`PPW_WAKE_SCLR] = sclr_q;
    wake_rd[`PPW_WAKE_F1 +: 2] = f1_q;
    wake_rd[`PPW_WAKE_F2 +: 2] = f2_q;
  end

  assign ctrl_w = be_merge(ctrl_rd, i_avs_writedata, i_avs_byteenable);
  assign imask_w = be_merge(imask_rd, i_avs_writedata, i_avs_byteenable);
  assign wake_w = be_merge(wake_rd, i_avs_writedata, i_avs_byteenable);
  assign misc_w = be_merge({16'h0000, misc_q}, i_avs_writedata,
                           i_avs_byteenable);
  assign clr_w = be_merge(32'h0000_0000, i_avs_writedata, i_avs_byteenable);

  always_comb begin
    unique case (i_avs_address)
      `PPW_OFF_CTRL: rd_mux = ctrl_rd;
      `PPW_OFF_STAT: begin
        rd_mux = 32'h0000_0000;
        rd_mux[`PPW_STAT_ENERGY] = line_energy_q;
        rd_mux[`PPW_STAT_SLEEP] = sleeping;
        rd_mux[`PPW_STAT_PD] = o_xcvr_power_down;
        rd_mux[`PPW_STAT_STRAP1] = strap1_q;
        rd_mux[`PPW_STAT_STRAP2] = strap2_q;
      end
      `PPW_OFF_IMASK: rd_mux = imask_rd;
      `PPW_OFF_ISRC: begin
        rd_mux = 32'h0000_0000;
        rd_mux[`PPW_IRQ_ENERGY] = isrc_q[0];
        rd_mux[`PPW_IRQ_WOL] = isrc_q[1];
      end
      `PPW_OFF_WAKE: rd_mux = wake_rd;
      `PPW_OFF_MISC: rd_mux = {16'h0000, misc_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave: one wait cycle, then accept
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if ((i_avs_read || i_avs_write) && wait_q) begin
        wait_q <= 1'b0;
        rdata_q <= i_avs_read ? rd_mux : 32'h0000_0000;
      end else begin
        wait_q <= 1'b1;
      end
    end
  end

  // control register, cleared by either reset
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      {rxint_q, single_q, txint_q, txnlp_q, energy_detect_sleep_en_q, pd_q} <= 8'h00;
      imask_q <= 2'h0;
      pd_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      pd_prev_q <= pd_q;
      if (i_soft_rst) begin
        {rxint_q, single_q, txint_q, txnlp_q, energy_detect_sleep_en_q, pd_q} <= 8'h00;
        imask_q <= 2'h0;
      end else if (wr_acc && i_avs_address == `PPW_OFF_CTRL) begin
        pd_q <= ctrl_w[`PPW_CTRL_PD];
        energy_detect_sleep_en_q <= ctrl_w[`PPW_CTRL_ENERGY_DETECT_SLEEP];
        txnlp_q <= ctrl_w[`PPW_CTRL_TXNLP];
        txint_q <= ctrl_w[`PPW_CTRL_TXINT +: 2];
        single_q <= ctrl_w[`PPW_CTRL_SINGLE];
        rxint_q <= ctrl_w[`PPW_CTRL_RXINT +: 2];
      end else if (wr_acc && i_avs_address == `PPW_OFF_IMASK) begin
        imask_q <= {imask_w[`PPW_IRQ_WOL], imask_w[`PPW_IRQ_ENERGY]};
      end
    end
  end

  // interrupt sources, set beats clear
  always_comb begin
    isrc_d = isrc_q;
    if (wr_acc && i_avs_address == `PPW_OFF_ISRC) begin
      isrc_d = isrc_d & ~{clr_w[`PPW_IRQ_WOL], clr_w[`PPW_IRQ_ENERGY]};
    end
    isrc_d = isrc_d | {wake_evt, energy_evt};
    rcv_d = rcv_q;
    if (wr_acc && i_avs_address == `PPW_OFF_WAKE) begin
      rcv_d = rcv_d & ~clr_w[`PPW_WAKE_RCV +: 4];
    end
    rcv_d = rcv_d | (i_frame_match & wen_q);
  end

  assign irq_lvl = |(isrc_q & imask_q);

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      isrc_q <= 2'h0;
    end else if (i_clk_en) begin
      isrc_q <= i_soft_rst ? 2'h0 : isrc_d;
    end
  end

  // wake registers ignore software reset
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      {f2_q, f1_q, sclr_q, wconf_q, rcv_q, wen_q} <= 14'h0000;
      misc_q <= 16'(`PPW_MISC_RST);
    end else if (i_clk_en) begin
      rcv_q <= rcv_d;
      if (wr_acc && i_avs_address == `PPW_OFF_WAKE) begin
        wen_q <= wake_w[`PPW_WAKE_EN +: 4];
        wconf_q <= wake_w[`PPW_WAKE_CONF];
        sclr_q <= wake_w[`PPW_WAKE_SCLR];
        f1_q <= wake_w[`PPW_WAKE_F1 +: 2];
        f2_q <= wake_w[`PPW_WAKE_F2 +: 2];
      end
      if (wr_acc && i_avs_address == `PPW_OFF_MISC) begin
        misc_q <= misc_w[15:0];
      end
    end
  end

  // wake output level with optional self clear
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wake_act_q <= 1'b0;
      sc_cnt_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (wake_evt) begin
        wake_act_q <= 1'b1;
        sc_cnt_q <= 32'(int'(misc_q) * US_CYC);
      end else if (rcv_d == 4'h0) begin
        wake_act_q <= 1'b0;
      end else if (wake_act_q && sclr_q) begin
        if (sc_cnt_q <= 32'h0000_0001) begin
          wake_act_q <= 1'b0;
        end else begin
          sc_cnt_q <= sc_cnt_q - 32'h0000_0001;
        end
      end
    end
  end

  // energy-detect sleep sequencer
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_q <= PPW_ST_ON;
      win_cnt_q <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        st_q <= PPW_ST_ON;
      end else begin
        unique case (st_q)
          PPW_ST_ON: begin
            if (energy_detect_sleep_en_q && !line_energy_q && !i_nlp_rx && !i_rx_energy) begin
              st_q <= PPW_ST_SLEEP;
            end
          end
          PPW_ST_SLEEP: begin
            win_cnt_q <= 32'h0000_0000;
            if (!energy_detect_sleep_en_q) begin
              st_q <= PPW_ST_ON;
            end else if (i_rx_energy || (i_nlp_rx && single_q)) begin
              st_q <= PPW_ST_WAKE;
            end else if (i_nlp_rx) begin
              st_q <= PPW_ST_ARMED;
            end
          end
          PPW_ST_ARMED: begin
            win_cnt_q <= win_cnt_q + 32'h0000_0001;
            if (!energy_detect_sleep_en_q) begin
              st_q <= PPW_ST_ON;
            end else if (i_nlp_rx || i_rx_energy) begin
              st_q <= PPW_ST_WAKE;
            end else if (win_cnt_q >= rx_lim) begin
              st_q <= PPW_ST_SLEEP;
            end
          end
          PPW_ST_WAKE: st_q <= PPW_ST_ON;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      line_energy_q <= 1'b0;
    end else if (i_clk_en) begin
      if (i_soft_rst) begin
        line_energy_q <= 1'b0;
      end else if (st_q == PPW_ST_WAKE) begin
        line_energy_q <= 1'b1;
      end else if (st_q == PPW_ST_ON && (i_nlp_rx || i_rx_energy)) begin
        line_energy_q <= 1'b1;
      end else if (i_energy_lost) begin
        line_energy_q <= 1'b0;
      end
    end
  end

  // link pulse transmit timer while asleep
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      nlp_cnt_q <= 32'h0000_0000;
      o_tx_nlp <= 1'b0;
    end else if (i_clk_en) begin
      o_tx_nlp <= 1'b0;
      if (!sleeping || !txnlp_q || pd_q) begin
        nlp_cnt_q <= 32'h0000_0000;
      end else if (nlp_cnt_q + 32'h0000_0001 >= tx_lim) begin
        nlp_cnt_q <= 32'h0000_0000;
        o_tx_nlp <= 1'b1;
      end else begin
        nlp_cnt_q <= nlp_cnt_q + 32'h0000_0001;
      end
    end
  end

  // activity blink phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end else if (i_clk_en) begin
      if (blink_cnt_q + 32'h0000_0001 >= 32'(BLINK_CYC)) begin
        blink_cnt_q <= 32'h0000_0000;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
    end
  end

  assign act_lvl = i_link_up && !(i_carrier_sense && blink_q);

  // pins and power outputs
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_indicator_one <= 1'b0;
      o_indicator_two <= 1'b0;
      o_interrupt_out_n <= 1'b1;
      o_refclk_output_en <= 1'b0;
      o_xcvr_power_down <= 1'b0;
      o_energy_detect_sleep <= 1'b0;
      o_xcvr_reset <= 1'b0;
      o_rx_drop <= 1'b0;
    end else if (i_clk_en) begin
      o_indicator_one <= pin_val(f1_q, act_lvl, act_lvl, irq_lvl,
                                 wake_act_q, strap1_q);
      o_indicator_two <= pin_val(f2_q, i_speed_100 && !i_isolate, act_lvl,
                                 irq_lvl, wake_act_q,
                                 strap2_q);
      o_interrupt_out_n <= !(strap2_q && |(isrc_d & imask_q));
      o_refclk_output_en <= !strap2_q && !pd_q && !sleeping;
      o_xcvr_power_down <= pd_q || sleeping;
      o_energy_detect_sleep <= sleeping;
      o_xcvr_reset <= (pd_prev_q && !pd_q) || energy_evt;
      o_rx_drop <= energy_evt;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;

  property p_strap_hold;
    @(posedge i_mclk) disable iff (i_sys_rst)
      !$changed(strap1_q) && !$changed(strap2_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("strap changed outside hardware reset");

  property p_ind1_wake;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && f1_q == PPW_FN_WAKE)
        |=> o_indicator_one == ($past(wake_act_q) ^ strap1_q);
  endproperty
  a_ind1_wake: assert property (p_ind1_wake)
    else $error("indicator one wrong level or polarity");

  property p_ind2_wake;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && f2_q == PPW_FN_WAKE)
        |=> o_indicator_two == ($past(wake_act_q) ^ strap2_q);
  endproperty
  a_ind2_wake: assert property (p_ind2_wake)
    else $error("indicator two wrong level or polarity");

  property p_pd_refclk;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && pd_q) |=> o_xcvr_power_down && !o_refclk_output_en;
  endproperty
  a_pd_refclk: assert property (p_pd_refclk)
    else $error("power-down not reflected on outputs");

  property p_pd_reset;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && pd_prev_q && !pd_q) |=> o_xcvr_reset;
  endproperty
  a_pd_reset: assert property (p_pd_reset)
    else $error("no reset pulse after power-down cleared");

  property p_energy_detect_sleep_off;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && !energy_detect_sleep_en_q && sleeping) |=> st_q == PPW_ST_ON;
  endproperty
  a_energy_detect_sleep_off: assert property (p_energy_detect_sleep_off)
    else $error("sleep kept with enable cleared");

  property p_sleep_quiet;
    @(posedge i_mclk) disable iff (i_sys_rst)
      sleeping |-> !line_energy_q ##1
        (!$past(i_clk_en) || !o_refclk_output_en);
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("sleep with energy or clock out");

  property p_single_wake;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && !i_soft_rst && st_q == PPW_ST_SLEEP && energy_detect_sleep_en_q &&
       single_q && i_nlp_rx) |=> st_q == PPW_ST_WAKE ##1 line_energy_q;
  endproperty
  a_single_wake: assert property (p_single_wake)
    else $error("single pulse did not wake");

  property p_wol_irq;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && !i_soft_rst && wake_evt && imask_q[1] && strap2_q)
        |=> !o_interrupt_out_n;
  endproperty
  a_wol_irq: assert property (p_wol_irq)
    else $error("wake frame did not raise interrupt");

  property p_rcv_flag;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (i_clk_en && wake_evt) |=> (rcv_q & $past(i_frame_match & wen_q))
        == $past(i_frame_match & wen_q) && wake_act_q;
  endproperty
  a_rcv_flag: assert property (p_rcv_flag)
    else $error("received flag not set on wake frame");
endmodule

// ===== ppw_top_tb_top.sv
`timescale 1ns/1ns
`include "ppw_params.svh"
module ppw_top_tb_top
  import ppw_pkg::*;
;
  logic clk, rst, sr, s1, s2, link, crs, spd, iso, nlp, ener, lost, clk_en;
  logic [3:0] fm;
  logic [4:0] adr;
  logic rdx, wrx, wreq;
  logic [31:0] wdat, rdat, q;
  logic [3:0] be;
  logic ind1, ind2, irq_n, rce, pd, eds, xr, txn, drop;
  int failures, checks_done, c;
  int ctrl_m, imask_m, isrc_m, wake_m, misc_m;

  ppw_top #(.MS_CYC(10), .BLINK_CYC(4)) ppw_top_i (
    .i_mclk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_soft_rst(sr),
    .i_regulator_disable_strap_strap(s1), .i_irq_pin_select_strap(s2), .i_link_up(link),
    .i_carrier_sense(crs), .i_speed_100(spd), .i_isolate(iso),
    .i_nlp_rx(nlp), .i_rx_energy(ener), .i_energy_lost(lost),
    .i_frame_match(fm), .i_avs_address(adr), .i_avs_read(rdx),
    .i_avs_write(wrx), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .o_indicator_one(ind1), .o_indicator_two(ind2),
    .o_interrupt_out_n(irq_n), .o_refclk_output_en(rce),
    .o_xcvr_power_down(pd), .o_energy_detect_sleep(eds),
    .o_xcvr_reset(xr), .o_tx_nlp(txn), .o_rx_drop(drop));

  ppw_host_model ppw_host_model_i (
    .i_mclk(clk), .i_waitrequest(wreq), .i_readdata(rdat),
    .o_address(adr), .o_read(rdx), .o_write(wrx), .o_writedata(wdat),
    .o_byteenable(be));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {rst, sr, s1, s2, link, crs, iso, nlp, ener, lost} = 10'h200;
    {spd, clk_en} = 2'h3;
    fm = 4'h0;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(20 * 40000);
    failures++;
    stop_test();
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [31:0] mdl(input int i);
    case (i)
      0: return ctrl_m;
      2: return imask_m;
      3: return isrc_m;
      4: return wake_m;
      5: return misc_m;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic wrm(input logic [4:0] a, input logic [31:0] d);
    ppw_host_model_i.wr(a, d);
    case (a)
      `PPW_OFF_CTRL: ctrl_m = d & 32'h0000_0377;
      `PPW_OFF_IMASK: imask_m = d & 32'h0000_0102;
      `PPW_OFF_ISRC: isrc_m = isrc_m & ~d;
      `PPW_OFF_WAKE: wake_m = (d & 32'h0000_3f0f) | (wake_m & ~d & 'hf0);
      `PPW_OFF_MISC: misc_m = d & 32'h0000_ffff;
      default: ;
    endcase
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                     input string n);
    ppw_host_model_i.rd(a, q);
    chk(n, e, q);
  endtask

  task automatic regs();
    for (int i = 0; i < 7; i++) begin
      if (i != 1) rdc(5'(i * 4), mdl(i), "reg");
    end
  endtask

  task automatic pul(input logic [2:0] v, input logic [3:0] f);
    @(posedge clk);
    {nlp, ener, lost} <= v;
    fm <= f;
    @(posedge clk);
    {nlp, ener, lost} <= 3'h0;
    fm <= 4'h0;
  endtask

  task automatic cnt(input int s, input int n, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if ((s == 0 && txn === 1'b1) || (s == 1 && xr === 1'b1) ||
          (s == 2 && drop === 1'b1) || (s == 3 && ind1 === 1'b0)) k++;
    end
  endtask

  task automatic hw(input logic a, input logic b);
    @(posedge clk);
    rst <= 1'b1;
    s1 <= a;
    s2 <= b;
    tick(5);
    rst <= 1'b0;
    {ctrl_m, imask_m, isrc_m, wake_m} = '0;
    misc_m = 32'h0000_0064;
    tick(2);
  endtask

  initial begin
    void'($urandom(32'ha7e9_2937));
    hw(1'b0, 1'b0);
    chk("ind1", 1'h0, ind1);
    chk("ind2", 1'h1, ind2);
    regs();
    rdc(`PPW_OFF_STAT, 32'h0000_0000, "stat");
    wrm(`PPW_OFF_MISC, $urandom);
    wrm(5'h18, $urandom);
    regs();
    chk("refclk", 1'h1, rce);
    @(posedge clk);
    link <= 1'b1;
    iso <= 1'b1;
    tick(3);
    chk("ind1", 1'h1, ind1);
    chk("ind2", 1'h0, ind2);
    wrm(`PPW_OFF_WAKE, 32'h0000_3000);
    tick(3);
    chk("ind2_act", 1'h1, ind2);
    crs <= 1'b1;
    cnt(3, 16, c);
    chk("blink", 1'h1, c > 0 && c < 16);
    crs <= 1'b0;
    wrm(`PPW_OFF_WAKE, 32'h0000_0000);
    link <= 1'b0;
    iso <= 1'b0;
    wrm(`PPW_OFF_CTRL, 32'h0000_0036);
    tick(3);
    chk("sleep", 1'h1, eds);
    chk("pd", 1'h1, pd);
    chk("refclk", 1'h0, rce);
    cnt(0, 2700, c);
    chk("nlp_on", 1'h1, c > 0);
    wrm(`PPW_OFF_CTRL, 32'h0000_0032);
    tick(2);
    cnt(0, 2700, c);
    chk("nlp_off", 1'h0, c > 0);
    pul(3'h4, 4'h0);
    tick(10);
    chk("one_pulse", 1'h1, eds);
    pul(3'h4, 4'h0);
    tick(3);
    chk("two_pulse", 1'h0, eds);
    pul(3'h1, 4'h0);
    tick(3);
    chk("resleep", 1'h1, eds);
    pul(3'h2, 4'h0);
    cnt(2, 6, c);
    chk("drop", 1'h1, c > 0);
    chk("wake", 1'h0, eds);
    chk("refclk", 1'h1, rce);
    rdc(`PPW_OFF_STAT, 32'h0000_0001, "stat");
    wrm(`PPW_OFF_CTRL, 32'h0000_0000);
    pul(3'h1, 4'h0);
    tick(3);
    chk("sleep_off", 1'h0, eds);
    wrm(`PPW_OFF_CTRL, 32'h0000_0001);
    tick(3);
    chk("pd", 1'h1, pd);
    chk("refclk", 1'h0, rce);
    rdc(`PPW_OFF_STAT, 32'h0000_0004, "stat");
    wrm(`PPW_OFF_CTRL, 32'h0000_0000);
    cnt(1, 6, c);
    chk("xreset", 1'h1, c > 0);
    chk("pd", 1'h0, pd);
    hw(1'b1, 1'b1);
    s1 <= 1'b0;
    s2 <= 1'b0;
    rdc(`PPW_OFF_STAT, 32'h0000_0018, "stat");
    chk("ind1", 1'h1, ind1);
    chk("ind2", 1'h0, ind2);
    wrm(`PPW_OFF_IMASK, 32'h0000_0002);
    wrm(`PPW_OFF_CTRL, 32'h0000_0042);
    tick(3);
    chk("sleep", 1'h1, eds);
    pul(3'h4, 4'h0);
    tick(3);
    chk("single", 1'h0, eds);
    chk("irq_n", 1'h0, irq_n);
    isrc_m = 32'h0000_0002;
    rdc(`PPW_OFF_ISRC, isrc_m, "isrc");
    wrm(`PPW_OFF_ISRC, 32'h0000_0002);
    wrm(`PPW_OFF_CTRL, 32'h0000_0000);
    tick(2);
    chk("irq_n", 1'h1, irq_n);
    ppw_host_model_i.arm_wake();
    imask_m = 32'h0000_0100;
    wrm(`PPW_OFF_WAKE, 32'h0000_090f);
    for (int k = 0; k < 4; k++) begin
      pul(3'h0, 4'(1 << k));
      tick(2);
      wake_m = wake_m | (1 << (k + 4));
      isrc_m = isrc_m | 32'h0000_0100;
      chk("irq_n", 1'h0, irq_n);
      chk("wake_pin", 1'h0, ind1);
      rdc(`PPW_OFF_WAKE, wake_m, "wake");
      wrm(`PPW_OFF_ISRC, 32'h0000_0100);
      tick(2);
      chk("irq_clr", 1'h1, irq_n);
      chk("wake_hold", 1'h0, ind1);
      wrm(`PPW_OFF_WAKE, wake_m | 32'h0000_00f0);
      tick(2);
      chk("wake_clr", 1'h1, ind1);
    end
    wrm(`PPW_OFF_WAKE, 32'h0000_0900);
    pul(3'h0, 4'hf);
    tick(2);
    chk("irq_n", 1'h1, irq_n);
    chk("wake_pin", 1'h1, ind1);
    rdc(`PPW_OFF_WAKE, wake_m, "wake");
    wrm(`PPW_OFF_IMASK, 32'h0000_0000);
    wrm(`PPW_OFF_WAKE, 32'h0000_090f);
    pul(3'h0, 4'hf);
    tick(2);
    wake_m = wake_m | 32'h0000_00f0;
    chk("irq_n", 1'h1, irq_n);
    @(posedge clk);
    sr <= 1'b1;
    @(posedge clk);
    sr <= 1'b0;
    tick(2);
    {ctrl_m, imask_m, isrc_m} = '0;
    regs();
    chk("wake_pin", 1'h0, ind1);
    wrm(`PPW_OFF_MISC, 32'h0000_0002);
    wrm(`PPW_OFF_WAKE, 32'h0000_0b0f);
    pul(3'h0, 4'h1);
    tick(90);
    chk("sc_hold", 1'h0, ind1);
    tick(20);
    chk("sc_end", 1'h1, ind1);
    rdc(`PPW_OFF_WAKE, wake_m, "wake");
    @(posedge clk);
    clk_en <= 1'b0;
    pul(3'h0, 4'h1);
    tick(2);
    clk_en <= 1'b1;
    tick(2);
    chk("frozen", 1'h1, ind1);
    stop_test();
  end
endmodule
